//--- mic_defs.vh
// Behaviour
// - Seven configurable request pins plus three internal sources
// - Internal sources behave alike in every mode
// - Fully nested pins get internally generated types
// - In-service flag per source blocks lower requests
// - Same source blocked while its flag set
// - Only equal or higher others may preempt
// - Cascade turns third/fourth pin into acknowledge
// - Two acknowledge cycles, type taken on second
// - Each pair cascades by its own control bit
// - Up to 128 sources, eight priority levels
// - Special nesting enabled by bit on first two pins only
// - Special nesting accepts same pin, still sets flag
// - Poll word: bit 15 pending, 4:0 type
// - Poll read sets winner's in-service flag
// - Poll status read leaves flags unchanged
// - Non-specific end clears highest in-service flag
// - Specific end clears only the named source
// - Three-bit priority, zero most urgent
// - Reset: priority ones, masked, edge, flags cleared
// - Cascade enable bit 5, special nesting bit 6
// - Locked acknowledges, two idle states, ready waits
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH

// Source count and fixed order, index 0 most urgent
`define MIC_NSRC 10
`define MIC_S_TMR 4'h0
`define MIC_S_E5 4'h1
`define MIC_S_E6 4'h2
`define MIC_S_E0 4'h3
`define MIC_S_E1 4'h4
`define MIC_S_E2 4'h5
`define MIC_S_E3 4'h6
`define MIC_S_E4 4'h7
`define MIC_S_SP0 4'h8
`define MIC_S_SP1 4'h9

// Interrupt type codes
`define MIC_T_TMR 5'h08
`define MIC_T_E5 5'h0A
`define MIC_T_E6 5'h0B
`define MIC_T_E0 5'h0C
`define MIC_T_E1 5'h0D
`define MIC_T_E2 5'h0E
`define MIC_T_E3 5'h0F
`define MIC_T_E4 5'h10
`define MIC_T_SP0 5'h14
`define MIC_T_SP1 5'h15

// Control word fields
`define MIC_F_PR 2:0
`define MIC_F_MSK 3
`define MIC_F_LTM 4
`define MIC_F_CAS 5
`define MIC_F_SFN 6
`define MIC_CTL_RST 7'h0F
`define MIC_WM_CAS 7'h7F
`define MIC_WM_PIN 7'h1F
`define MIC_WM_INT 7'h0F
`define MIC_PMSK_RST 3'h7

// Poll word layout
`define MIC_POLL_PEND 15
`define MIC_POLL_TYPE 4:0

// Idle states between acknowledge cycles
`define MIC_GAP_LAST 2'h1

`endif

//--- mic_prio_resolve.v
`timescale 1ns/1ns
`include "mic_defs.vh"
module mic_prio_resolve (
   // Source state
   input wire [9:0] i_req,
   input wire [9:0] i_mask,
   input wire [9:0] i_is,
   input wire [9:0] i_sfn,
   input wire [29:0] i_prio,
   input wire [2:0] i_prio_mask,
   // Results
   output wire o_pend,
   output wire [3:0] o_win,
   output wire o_is_any,
   output wire [3:0] o_is_top
);

   // Best of a set by level, then by fixed order
   function [4:0] mic_pick;
      input [9:0] v;
      input [29:0] p;
      integer i;
      reg found;
      reg [3:0] idx;
      reg [2:0] lv;
      begin
         found = 1'b0;
         idx = 4'h0;
         lv = 3'h7;
         for (i = 0; i < `MIC_NSRC; i = i + 1) begin
            // Strict compare keeps the earlier source on ties
            if (v[i] && (!found || p[3*i +: 3] < lv)) begin
               found = 1'b1;
               idx = i[3:0];
               lv = p[3*i +: 3];
            end
         end
         mic_pick = {found, idx};
      end
   endfunction

   wire [4:0] is_pick; // Highest in-service source
   wire [4:0] rq_pick; // Highest eligible request
   wire [2:0] is_lvl; // Level of that source
   wire [9:0] elig; // Requests allowed through

   assign is_pick = mic_pick(i_is, i_prio);
   assign is_lvl = i_prio[3*is_pick[3:0] +: 3];

   // Eligibility per source
   genvar g;
   generate
      for (g = 0; g < `MIC_NSRC; g = g + 1) begin : g_el
         wire [2:0] lv = i_prio[3*g +: 3];
         wire same = i_is[g] & ~i_sfn[g];
         wire pm_ok = (lv <= i_prio_mask);
         wire is_ok = ~is_pick[4] | (lv <= is_lvl);
         assign elig[g] = i_req[g] & ~i_mask[g] & ~same & pm_ok & is_ok;
      end
   endgenerate

   assign rq_pick = mic_pick(elig, i_prio);
   assign o_pend = rq_pick[4];
   assign o_win = rq_pick[3:0];
   assign o_is_any = is_pick[4];
   assign o_is_top = is_pick[3:0];
endmodule

//--- mic_ack_seq.v
`timescale 1ns/1ns
`include "mic_defs.vh"
module mic_ack_seq (
   // Clock and control
   input wire i_ref_clk,
   input wire i_nrst,
   input wire i_ce,
   // Start request
   input wire i_start,
   input wire i_sel,
   // Synchronised bus
   input wire i_ready,
   input wire [7:0] i_data,
   // Results
   output reg [1:0] o_ack_n,
   output reg o_busy,
   output reg o_lock,
   output reg o_done,
   output reg [7:0] o_type
);

   localparam ST_IDLE = 2'b00; // Waiting
   localparam ST_CYC1 = 2'b01; // First acknowledge
   localparam ST_GAP = 2'b10; // Idle states
   localparam ST_CYC2 = 2'b11; // Second acknowledge

   reg [1:0] state_ff; // Sequencer state
   reg [1:0] gap_ff; // Idle state counter
   reg sel_ff; // Which pair is served

   // Acknowledge sequencer
   always @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         state_ff <= ST_IDLE;
         gap_ff <= 2'h0;
         sel_ff <= 1'b0;
         o_ack_n <= 2'b11;
         o_busy <= 1'b0;
         o_lock <= 1'b0;
         o_done <= 1'b0;
         o_type <= 8'h00;
      end else if (i_ce) begin
         o_done <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               // Open first cycle on the chosen pin
               if (i_start) begin
                  sel_ff <= i_sel;
                  o_ack_n <= i_sel ? 2'b01 : 2'b10;
                  o_busy <= 1'b1;
                  o_lock <= 1'b1;
                  state_ff <= ST_CYC1;
               end
            end
            ST_CYC1: begin
               // Wait states until ready
               if (i_ready) begin
                  o_ack_n <= 2'b11;
                  gap_ff <= 2'h0;
                  state_ff <= ST_GAP;
               end
            end
            ST_GAP: begin
               // Two idle states between cycles
               gap_ff <= gap_ff + 2'h1;
               if (gap_ff == `MIC_GAP_LAST) begin
                  o_ack_n <= sel_ff ? 2'b01 : 2'b10;
                  state_ff <= ST_CYC2;
               end
            end
            default: begin
               // Type taken from the second cycle
               if (i_ready) begin
                  o_type <= i_data;
                  o_done <= 1'b1;
                  o_ack_n <= 2'b11;
                  o_busy <= 1'b0;
                  o_lock <= 1'b0;
                  state_ff <= ST_IDLE;
               end
            end
         endcase
      end
   end
endmodule

//--- mic_ctrl.v
`timescale 1ns/1ns
`include "mic_defs.vh"
module mic_ctrl (
   // Clock and control
   input wire i_ref_clk,
   input wire i_nrst,
   input wire i_ce,
   // External request pins, first at bit 0
   input wire [6:0] i_ext_request,
   // Internal sources
   input wire i_timer_irq,
   input wire [1:0] i_serial_irq,
   // Per-source control writes
   input wire i_cfg_wr,
   input wire [3:0] i_cfg_sel,
   input wire [6:0] i_cfg_data,
   // Priority mask write
   input wire i_prio_mask_wr,
   input wire [2:0] i_prio_mask_data,
   // End of service writes
   input wire i_end_of_service_write,
   input wire i_eos_nonspec,
   input wire [4:0] i_eos_type,
   // Poll reads
   input wire i_poll_rd,
   input wire i_poll_status_rd,
   // Core acknowledge
   input wire i_core_ack,
   // Cascade bus pins
   input wire i_ready,
   input wire [7:0] i_bus_data,
   // Core side results
   output reg o_int_req,
   output reg o_vec_valid,
   output reg [7:0] o_vec_type,
   output reg [15:0] o_poll_word,
   // State view
   output wire [9:0] o_in_service_flag,
   output wire [9:0] o_req_flags,
   output reg [2:0] o_prio_mask,
   // Cascade acknowledge pins
   output wire o_cascade_ack_first_n,
   output reg o_cascade_ack_first_oe,
   output wire o_cascade_ack_second_n,
   output reg o_cascade_ack_second_oe,
   output wire o_ack_lock
);

   // Source index to type code
   function [4:0] mic_type;
      input [3:0] idx;
      begin
         case (idx)
            `MIC_S_TMR: mic_type = `MIC_T_TMR;
            `MIC_S_E5: mic_type = `MIC_T_E5;
            `MIC_S_E6: mic_type = `MIC_T_E6;
            `MIC_S_E0: mic_type = `MIC_T_E0;
            `MIC_S_E1: mic_type = `MIC_T_E1;
            `MIC_S_E2: mic_type = `MIC_T_E2;
            `MIC_S_E3: mic_type = `MIC_T_E3;
            `MIC_S_E4: mic_type = `MIC_T_E4;
            `MIC_S_SP0: mic_type = `MIC_T_SP0;
            default: mic_type = `MIC_T_SP1;
         endcase
      end
   endfunction

   // Type code to one-hot source, zero if unknown
   function [9:0] mic_oh_of_type;
      input [4:0] t;
      integer i;
      begin
         mic_oh_of_type = 10'h000;
         for (i = 0; i < `MIC_NSRC; i = i + 1) begin
            if (mic_type(i[3:0]) == t) begin
               mic_oh_of_type[i] = 1'b1;
            end
         end
      end
   endfunction

   // Pin synchronisers, two stages
   reg [6:0] pin_s1_ff; // First stage
   reg [6:0] pin_s2_ff; // Second stage
   reg rdy_s1_ff; // Ready first stage
   reg rdy_s2_ff; // Ready second stage
   reg [7:0] dat_s1_ff; // Data first stage
   reg [7:0] dat_s2_ff; // Data second stage
   reg [9:0] src_prev_ff; // Previous source levels

   // Source vectors
   wire [9:0] src_in; // Current source levels
   wire [69:0] ctl_all; // Control words
   wire [29:0] prio_v; // Priority fields
   wire [9:0] mask_v; // Mask bits
   wire [9:0] sfn_v; // Special nesting bits
   wire [9:0] req_v; // Request flags
   wire [9:0] is_v; // In-service flags
   wire [9:0] dis_v; // Pins turned into acknowledges
   wire [9:0] set_is; // In-service set strobes
   wire [9:0] clr_is; // In-service clear strobes

   // Resolver results
   wire pend;
   wire [3:0] win;
   wire is_any;
   wire [3:0] is_top;

   // Sequencer results
   wire [1:0] seq_ack_n;
   wire seq_busy;
   wire seq_done;
   wire [7:0] seq_type;

   // Cascade selections
   wire cas_first;
   wire cas_second;
   wire take_core;
   wire take_poll;
   wire win_cas;
   wire [9:0] win_oh;
   wire [9:0] eos_oh;

   // Synchronise all pin inputs
   always @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         pin_s1_ff <= 7'h00;
         pin_s2_ff <= 7'h00;
         rdy_s1_ff <= 1'b0;
         rdy_s2_ff <= 1'b0;
         dat_s1_ff <= 8'h00;
         dat_s2_ff <= 8'h00;
         src_prev_ff <= 10'h000;
      end else if (i_ce) begin
         pin_s1_ff <= i_ext_request;
         pin_s2_ff <= pin_s1_ff;
         rdy_s1_ff <= i_ready;
         rdy_s2_ff <= rdy_s1_ff;
         dat_s1_ff <= i_bus_data;
         dat_s2_ff <= dat_s1_ff;
         src_prev_ff <= src_in;
      end
   end

   // Map pins and internal sources to fixed order
   assign src_in = {i_serial_irq[1], i_serial_irq[0], pin_s2_ff[4],
      pin_s2_ff[3], pin_s2_ff[2], pin_s2_ff[1], pin_s2_ff[0],
      pin_s2_ff[6], pin_s2_ff[5], i_timer_irq};

   // Cascade bits of first and second control words
   assign cas_first = ctl_all[7*`MIC_S_E0 + `MIC_F_CAS];
   assign cas_second = ctl_all[7*`MIC_S_E1 + `MIC_F_CAS];

   // Third and fourth pins stop requesting in cascade
   assign dis_v = ({9'h000, cas_first} << `MIC_S_E2)
      | ({9'h000, cas_second} << `MIC_S_E3);

   // Winner acceptance by core or poll read
   assign take_core = i_core_ack & o_int_req & ~seq_busy & pend;
   assign take_poll = i_poll_rd & pend;
   assign win_oh = 10'h001 << win;
   assign set_is = (take_core | take_poll) ? win_oh : 10'h000;

   // End of service target
   assign eos_oh = i_eos_nonspec ? (is_any ? (10'h001 << is_top) : 10'h000)
      : mic_oh_of_type(i_eos_type);
   assign clr_is = i_end_of_service_write ? eos_oh : 10'h000;

   // Winner served by an external controller
   assign win_cas = (win == `MIC_S_E0 && cas_first)
      || (win == `MIC_S_E1 && cas_second);

   // Per-source control, request and in-service state
   genvar g;
   generate
      for (g = 0; g < `MIC_NSRC; g = g + 1) begin : g_src
         // Writable bits depend on the source kind
         localparam [6:0] WM = (g == `MIC_S_E0 || g == `MIC_S_E1) ? `MIC_WM_CAS :
            (g >= `MIC_S_E5 && g <= `MIC_S_E4) ? `MIC_WM_PIN : `MIC_WM_INT;
         reg [6:0] ctl_ff; // Control word
         reg req_ff; // Request flag
         reg is_ff; // In-service flag
         wire rise = src_in[g] & ~src_prev_ff[g];

         // Control word register
         always @(posedge i_ref_clk) begin
            if (!i_nrst) begin
               ctl_ff <= `MIC_CTL_RST;
            end else if (i_ce && i_cfg_wr && i_cfg_sel == g) begin
               ctl_ff <= i_cfg_data & WM;
            end
         end

         // Request flag, edge or level
         always @(posedge i_ref_clk) begin
            if (!i_nrst) begin
               req_ff <= 1'b0;
            end else if (i_ce) begin
               if (ctl_ff[`MIC_F_LTM]) begin
                  // Level mode follows the pin
                  req_ff <= src_in[g];
               end else begin
                  // Edge sets, acceptance clears, set wins
                  req_ff <= rise | (req_ff & ~set_is[g]);
               end
            end
         end

         // In-service flag, set wins over clear
         always @(posedge i_ref_clk) begin
            if (!i_nrst) begin
               is_ff <= 1'b0;
            end else if (i_ce) begin
               is_ff <= set_is[g] | (is_ff & ~clr_is[g]);
            end
         end

         assign ctl_all[7*g +: 7] = ctl_ff;
         assign prio_v[3*g +: 3] = ctl_ff[`MIC_F_PR];
         assign mask_v[g] = ctl_ff[`MIC_F_MSK] | dis_v[g];
         assign sfn_v[g] = ctl_ff[`MIC_F_SFN];
         assign req_v[g] = req_ff;
         assign is_v[g] = is_ff;
      end
   endgenerate

   // Priority resolution, same for all internal sources
   mic_prio_resolve u_res (
      .i_req(req_v),
      .i_mask(mask_v),
      .i_is(is_v),
      .i_sfn(sfn_v),
      .i_prio(prio_v),
      .i_prio_mask(o_prio_mask),
      .o_pend(pend),
      .o_win(win),
      .o_is_any(is_any),
      .o_is_top(is_top)
   );

   // Cascade acknowledge sequencer
   mic_ack_seq u_seq (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .i_start(take_core & win_cas),
      .i_sel(win == `MIC_S_E1),
      .i_ready(rdy_s2_ff),
      .i_data(dat_s2_ff),
      .o_ack_n(seq_ack_n),
      .o_busy(seq_busy),
      .o_lock(o_ack_lock),
      .o_done(seq_done),
      .o_type(seq_type)
   );

   assign o_cascade_ack_first_n = seq_ack_n[0];
   assign o_cascade_ack_second_n = seq_ack_n[1];
   assign o_in_service_flag = is_v;
   assign o_req_flags = req_v;

   // Priority mask and pin direction
   always @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_prio_mask <= `MIC_PMSK_RST;
         o_cascade_ack_first_oe <= 1'b0;
         o_cascade_ack_second_oe <= 1'b0;
      end else if (i_ce) begin
         if (i_prio_mask_wr) begin
            o_prio_mask <= i_prio_mask_data;
         end
         o_cascade_ack_first_oe <= cas_first;
         o_cascade_ack_second_oe <= cas_second;
      end
   end

   // Core request line and vector delivery
   always @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_int_req <= 1'b0;
         o_vec_valid <= 1'b0;
         o_vec_type <= 8'h00;
      end else if (i_ce) begin
         // Request held off while acknowledging
         o_int_req <= pend & ~seq_busy & ~take_core & ~take_poll;
         o_vec_valid <= 1'b0;
         if (seq_done) begin
            // Type supplied externally
            o_vec_valid <= 1'b1;
            o_vec_type <= seq_type;
         end else if (take_core && !win_cas) begin
            // Type generated internally
            o_vec_valid <= 1'b1;
            o_vec_type <= {3'h0, mic_type(win)};
         end
      end
   end

   // Poll word capture on either poll read
   always @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         o_poll_word <= 16'h0000;
      end else if (i_ce && (i_poll_rd || i_poll_status_rd)) begin
         o_poll_word <= 16'h0000;
         o_poll_word[`MIC_POLL_PEND] <= pend;
         o_poll_word[`MIC_POLL_TYPE] <= mic_type(win);
      end
   end
endmodule

//--- mic_ctrl_asserts.sv
`timescale 1ns/1ns
`include "mic_defs.vh"
module mic_ctrl_asserts (
   // Clock and control
   input wire i_ref_clk,
   input wire i_nrst,
   input wire i_ce,
   // Writes and reads
   input wire i_prio_mask_wr,
   input wire [2:0] i_prio_mask_data,
   input wire i_end_of_service_write,
   input wire i_eos_nonspec,
   input wire [4:0] i_eos_type,
   input wire i_poll_rd,
   input wire i_poll_status_rd,
   input wire i_core_ack,
   // Results
   input wire o_int_req,
   input wire o_vec_valid,
   input wire [15:0] o_poll_word,
   input wire [9:0] o_in_service_flag,
   input wire [9:0] o_req_flags,
   input wire [2:0] o_prio_mask,
   input wire o_cascade_ack_first_n,
   input wire o_cascade_ack_first_oe,
   input wire o_cascade_ack_second_n,
   input wire o_cascade_ack_second_oe,
   input wire o_ack_lock
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   // No accept and no end write in this cycle
   wire quiet = i_ce && !i_core_ack && !i_poll_rd && !i_end_of_service_write;

   a_reset_values: assert property (disable iff (1'b0) !i_nrst && i_ce |=> !o_int_req && !o_ack_lock &&
      o_in_service_flag == 10'h000 && o_prio_mask == 3'h7 && o_cascade_ack_first_n && !o_cascade_ack_first_oe)
      else $error("reset state wrong");
   a_int_needs_req: assert property (o_int_req |-> $past(o_req_flags) != 10'h000)
      else $error("interrupt without request");
   a_vec_sets_flag: assert property (o_vec_valid |-> o_in_service_flag != 10'h000)
      else $error("vector without in-service flag");
   a_ack_in_lock: assert property ($fell(o_cascade_ack_first_n) || $fell(o_cascade_ack_second_n) |-> o_ack_lock)
      else $error("acknowledge outside lock");
   a_ack_idle_gap: assert property ($rose(o_cascade_ack_first_n) && o_ack_lock |=> o_cascade_ack_first_n)
      else $error("idle gap too short");
   a_first_ack_oe: assert property (!o_cascade_ack_first_oe |-> o_cascade_ack_first_n)
      else $error("first acknowledge without cascade");
   a_second_ack_oe: assert property (!o_cascade_ack_second_oe |-> o_cascade_ack_second_n)
      else $error("second acknowledge without cascade");
   a_eos_specific: assert property (i_ce && !i_core_ack && !i_poll_rd && i_end_of_service_write &&
      !i_eos_nonspec && i_eos_type == `MIC_T_TMR |=> !o_in_service_flag[0]) else $error("specific end did not clear");
   a_status_no_side: assert property (i_poll_status_rd && quiet |=> $stable(o_in_service_flag))
      else $error("status read changed flags");
   a_poll_sets_flag: assert property (i_poll_rd && i_ce |=> !o_poll_word[15] || o_in_service_flag != 10'h000)
      else $error("poll read set no flag");
   a_mask_write: assert property (i_prio_mask_wr && i_ce |=> o_prio_mask == $past(i_prio_mask_data))
      else $error("priority mask not written");
   // Main scenarios
   cover property (o_vec_valid && $past(o_ack_lock));
   cover property ($fell(o_cascade_ack_second_n));
   cover property (o_poll_word[15]);
endmodule

//--- mic_cascade_model.sv
`timescale 1ns/1ns
module mic_cascade_model (
   // Clock
   input wire i_ref_clk,
   // Acknowledge wires, active low
   input wire i_ack_first_n,
   input wire i_ack_second_n,
   // Type to return and wait states
   input wire [7:0] i_type,
   input wire [3:0] i_wait,
   // Bus answer
   output reg o_ready,
   output reg [7:0] o_data
);
   reg ack_q_ff = 1'b1; // Previous acknowledge level
   reg [1:0] cyc_ff = 2'h0; // Acknowledge cycle number
   reg [3:0] cnt_ff = 4'h0; // Cycles into the acknowledge
   reg [7:0] pat_ff = 8'h5A; // Filler, never the last value
   // Either pair; an undriven pin before reset counts as idle
   wire ack_n = (i_ack_first_n !== 1'b0) && (i_ack_second_n !== 1'b0);
   wire fall = ack_q_ff & ~ack_n; // Start of a cycle
   wire [1:0] nxt_cyc = fall ? ((cyc_ff == 2'h1) ? 2'h2 : 2'h1) : cyc_ff;
   initial begin
      o_ready = 1'b0;
      o_data = 8'hA5;
   end
   // One ready pulse per cycle after the wait states, so no stale ready
   // reaches the next cycle through the synchronisers; type only in cycle two
   always @(posedge i_ref_clk) begin
      ack_q_ff <= ack_n;
      cyc_ff <= nxt_cyc;
      cnt_ff <= fall ? 4'h0 : (cnt_ff == 4'hF ? cnt_ff : cnt_ff + 4'h1);
      pat_ff <= ~pat_ff;
      o_ready <= !ack_n && !fall && cnt_ff == i_wait;
      o_data <= (!ack_n && nxt_cyc == 2'h2) ? i_type : pat_ff;
   end
endmodule

//--- master_interrupt_controller_tb_top.sv
`timescale 1ns/1ns
`include "mic_defs.vh"
module master_interrupt_controller_tb_top;
   reg clk = 1'b0, nrst = 1'b0, ce = 1'b1, tmr = 1'b0, cfg_wr = 1'b0, pm_wr = 1'b0, eos_wr = 1'b0;
   reg eos_ns = 1'b0, poll_rd = 1'b0, stat_rd = 1'b0, cack = 1'b0;
   reg [6:0] ext = 7'h00, cfg_data = 7'h00;
   reg [1:0] ser = 2'h0;
   reg [3:0] cfg_sel = 4'h0, cwait = 4'h0;
   reg [2:0] pm_data = 3'h7;
   reg [4:0] eos_t = 5'h00;
   reg [7:0] casv = 8'h00;
   wire ready, int_req, vec_valid, ackf_n, ackf_oe, acks_n, acks_oe, lock;
   wire [7:0] bus, vec_type;
   wire [15:0] poll_w;
   wire [9:0] isf, rqf;
   wire [2:0] pmask;
   // Third and fourth pins carry the acknowledge while paired
   wire [6:0] ext_w = {ext[6:4], acks_oe ? acks_n : ext[3], ackf_oe ? ackf_n : ext[2], ext[1:0]};
   // Model state
   int pr[10];
   logic [9:0] mk, sf, ca, isv, rq;
   logic [7:0] tt[10] = '{8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h14, 8'h15};
   int pmv, bad_count, check_count, w, n, p, k;

   mic_ctrl uut (.i_ref_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_ext_request(ext_w), .i_timer_irq(tmr),
      .i_serial_irq(ser), .i_cfg_wr(cfg_wr), .i_cfg_sel(cfg_sel), .i_cfg_data(cfg_data), .i_prio_mask_wr(pm_wr),
      .i_prio_mask_data(pm_data), .i_end_of_service_write(eos_wr), .i_eos_nonspec(eos_ns), .i_eos_type(eos_t),
      .i_poll_rd(poll_rd), .i_poll_status_rd(stat_rd), .i_core_ack(cack), .i_ready(ready), .i_bus_data(bus),
      .o_int_req(int_req), .o_vec_valid(vec_valid), .o_vec_type(vec_type), .o_poll_word(poll_w),
      .o_in_service_flag(isf), .o_req_flags(rqf), .o_prio_mask(pmask), .o_cascade_ack_first_n(ackf_n),
      .o_cascade_ack_first_oe(ackf_oe), .o_cascade_ack_second_n(acks_n), .o_cascade_ack_second_oe(acks_oe),
      .o_ack_lock(lock));
   // Partner sees an acknowledge only while the pin is turned around
   mic_cascade_model partner (.i_ref_clk(clk), .i_ack_first_n(ackf_n | ~ackf_oe),
      .i_ack_second_n(acks_n | ~acks_oe), .i_type(casv), .i_wait(cwait), .o_ready(ready), .o_data(bus));

   // Compare and count
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task print_verdict;
      if (bad_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task tick(input int c);
      repeat (c) @(negedge clk);
   endtask
   // Expected winner, or -1 when nothing may interrupt
   function int win;
      int top, b;
      top = 7;
      b = -1;
      for (int i = 0; i < 10; i++) if (isv[i] && pr[i] < top) top = pr[i];
      for (int i = 0; i < 10; i++)
         if (rq[i] && !mk[i] && pr[i] <= pmv && pr[i] <= top && (sf[i] || !isv[i]) && (b < 0 || pr[i] < pr[b]))
            b = i;
      return b;
   endfunction
   task cfg(input int i, input logic [6:0] d);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_sel <= i[3:0];
      cfg_data <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
      pr[i] = d[2:0];
      mk[i] = d[3];
      sf[i] = d[6] && (i == 3 || i == 4);
      ca[i] = d[5] && (i == 3 || i == 4);
      tick(3);
   endtask
   // Request held a few cycles, then released
   task raise(input int i);
      @(posedge clk);
      if (i == 0) tmr <= 1'b1;
      else if (i > 7) ser[i-8] <= 1'b1;
      else ext[i == 1 ? 5 : i == 2 ? 6 : i - 3] <= 1'b1;
      repeat (4) @(posedge clk);
      tmr <= 1'b0;
      ser <= 2'h0;
      ext <= 7'h00;
      rq[i] = 1'b1;
      tick(4);
   endtask
   // Core accepts whatever is pending
   task take;
      w = win();
      chk("int_req", w >= 0, int_req);
      if (w >= 0) begin
         @(posedge clk);
         cack <= 1'b1;
         @(posedge clk);
         cack <= 1'b0;
         @(negedge clk);
         for (n = 0; n < 80 && vec_valid !== 1'b1; n++) @(negedge clk);
         chk("vec_valid", 1'b1, vec_valid);
         chk("vec_type", ca[w] ? casv : tt[w], vec_type);
         isv[w] = 1'b1;
         rq[w] = 1'b0;
      end
      tick(4);
      chk("in_service", isv, isf);
   endtask
   task poll(input bit rd);
      w = win();
      @(posedge clk);
      if (rd) poll_rd <= 1'b1;
      else stat_rd <= 1'b1;
      @(posedge clk);
      poll_rd <= 1'b0;
      stat_rd <= 1'b0;
      tick(2);
      chk("poll_pend", w >= 0, poll_w[15]);
      if (w >= 0) chk("poll_type", tt[w][4:0], poll_w[4:0]);
      if (rd && w >= 0) begin
         isv[w] = 1'b1;
         rq[w] = 1'b0;
      end
      tick(2);
      chk("in_service", isv, isf);
   endtask
   // End of service, model cleared first
   task eos(input bit ns, input logic [4:0] t);
      int b;
      b = -1;
      for (int i = 0; i < 10; i++) if (isv[i] && (ns ? (b < 0 || pr[i] < pr[b]) : tt[i][4:0] == t)) b = i;
      if (b >= 0) isv[b] = 1'b0;
      @(posedge clk);
      eos_wr <= 1'b1;
      eos_ns <= ns;
      eos_t <= t;
      @(posedge clk);
      eos_wr <= 1'b0;
      tick(4);
      chk("in_service", isv, isf);
   endtask
   task pmw(input logic [2:0] v);
      @(posedge clk);
      pm_wr <= 1'b1;
      pm_data <= v;
      @(posedge clk);
      pm_wr <= 1'b0;
      pmv = v;
      tick(3);
      chk("prio_mask", v, pmask);
   endtask

   initial begin
      forever #10 clk = ~clk;
   end
   // Hang guard
   initial begin
      #800000;
      bad_count++;
      print_verdict;
   end
   initial begin
      k = $urandom(32'hdc15);
      for (int i = 0; i < 10; i++) pr[i] = 7;
      {mk, sf, ca, isv, rq} = {10'h3FF, 40'h0};
      pmv = 7;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      tick(1);
      chk("reset", 32'h0F8, {int_req, isf, rqf, pmask, ackf_n, acks_n, ackf_oe, acks_oe, lock});
      raise(8);
      take;
      for (int i = 0; i < 10; i++) cfg(i, 7'h06);
      raise(1);
      raise(3);
      poll(1'b0);
      poll(1'b1);
      poll(1'b0);
      take;
      take;
      eos(1'b1, 5'h00);
      eos(1'b0, 5'h14);
      eos(1'b0, 5'h0C);
      // Nesting with a random upper level
      p = $urandom_range(5, 0);
      cfg(0, p[6:0]);
      cfg(1, p[6:0]);
      raise(0);
      take;
      raise(3);
      take;
      raise(0);
      take;
      raise(1);
      take;
      eos(1'b1, 5'h00);
      take;
      eos(1'b0, 5'h08);
      eos(1'b0, 5'h0A);
      take;
      eos(1'b1, 5'h00);
      raise(2);
      pmw(3'h5);
      take;
      pmw(3'h7);
      take;
      eos(1'b1, 5'h00);
      cfg(3, 7'h46);
      raise(3);
      take;
      raise(3);
      take;
      eos(1'b1, 5'h00);
      cfg(3, 7'h25);
      chk("ack_oe", 2'h2, {ackf_oe, acks_oe});
      cfg(4, 7'h26);
      chk("ack_oe", 2'h3, {ackf_oe, acks_oe});
      for (k = 0; k < 2; k++) begin
         casv = 8'($urandom);
         cwait = k ? 4'h3 : 4'h0;
         raise(3 + k);
         take;
         eos(1'b1, 5'h00);
      end
      print_verdict;
   end
endmodule
bind mic_ctrl mic_ctrl_asserts u_chk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ce(i_ce),
   .i_prio_mask_wr(i_prio_mask_wr), .i_prio_mask_data(i_prio_mask_data), .i_eos_type(i_eos_type),
   .i_end_of_service_write(i_end_of_service_write), .i_eos_nonspec(i_eos_nonspec), .i_poll_rd(i_poll_rd),
   .i_poll_status_rd(i_poll_status_rd), .i_core_ack(i_core_ack), .o_int_req(o_int_req), .o_vec_valid(o_vec_valid),
   .o_poll_word(o_poll_word), .o_in_service_flag(o_in_service_flag), .o_req_flags(o_req_flags),
   .o_prio_mask(o_prio_mask), .o_cascade_ack_first_n(o_cascade_ack_first_n), .o_ack_lock(o_ack_lock),
   .o_cascade_ack_first_oe(o_cascade_ack_first_oe), .o_cascade_ack_second_n(o_cascade_ack_second_n),
   .o_cascade_ack_second_oe(o_cascade_ack_second_oe));
